// File: inc/media_cfg_pkg.sv
// Purpose: Shared constants and types for media select and jumperless configuration
// Assumes: 50 MHz system clock, 10-bit ISA I/O address decode
// Notes:   Register offsets relative to the base I/O address are set here
package media_cfg_pkg;

  // System clock
  localparam int unsigned CLK_MHZ = 50;

  // Jumperless alias location and write count
  localparam logic [9:0] ALIAS_ADDR   = 10'h278;
  localparam logic [2:0] ALIAS_WRITES = 3'h4;

  // Register offsets from the selected base
  localparam logic [9:0] OFF_CFG_A = 10'h00A;
  localparam logic [9:0] OFF_CFG_B = 10'h00B;
  localparam logic [9:0] OFF_CFG_C = 10'h00C;

  // Field positions
  localparam int unsigned A_IOAD_LSB = 0;
  localparam int unsigned A_IOAD_MSB = 2;
  localparam int unsigned B_GDLINK   = 2;
  localparam int unsigned C_AUTOSW   = 4;
  localparam int unsigned C_SHIELD   = 6;
  localparam int unsigned C_LOCK     = 7;

  // Base address selection; the all-ones code is the reserved, jumperless mode
  localparam logic [2:0] IOAD_RESERVED = 3'h7;
  localparam logic [9:0] BASE_TABLE [8] = '{10'h300, 10'h280, 10'h340, 10'h320,
                                            10'h240, 10'h2C0, 10'h360, 10'h000};

  // Reset values
  localparam logic [7:0] CFG_A_RST = 8'h07;
  localparam logic [7:0] CFG_B_RST = 8'h00;
  localparam logic [7:0] CFG_C_RST = 8'h20;

  // Unjab interval and its cycle count (longest time, rounded down)
  localparam int unsigned UNJAB_TIME_US = 500;
  localparam int unsigned UNJAB_CYCLES  = UNJAB_TIME_US * CLK_MHZ;

  // One I/O bus request, strobes one cycle wide
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] data;
  } io_req_t;

  // Configuration register set
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } cfg_regs_t;

  // Port selection state, one-hot
  typedef enum logic [3:0] {
    ST_TP     = 4'h1,
    ST_TO_AUI = 4'h2,
    ST_AUI    = 4'h4,
    ST_TO_TP  = 4'h8
  } port_state_t;

endpackage

// File: verilog/unjab_timer.sv
// Purpose: Measures the quiet interval after jabbering ends
// Assumes: jabber_i synchronous to ref_clk_i
// Notes:   done_o stays low while jabbering and for CYCLES edges after
`timescale 1ns/1ps
`default_nettype none
module unjab_timer #(
  parameter int unsigned CYCLES = 25000
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic jabber_i,
  output logic      done_o
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         done_d;

  // Count restarts on every jabber cycle and saturates at the interval
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (jabber_i) begin
      cnt_d = '0;
    end else if (cnt_q != LAST) begin
      cnt_d = cnt_q + W'(1);
    end else begin
      done_d = 1'b1;
    end
  end

  // Starts done so that a link fail with no jabber history switches at once
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= LAST;
      done_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_d;
      done_o <= done_d;
    end
  end
endmodule
`default_nettype wire

// File: verilog/pair_drive.sv
// Purpose: Drives one twisted-pair output pair in UTP or STP manner
// Assumes: Output enables are active low
// Notes:   The idle leg is released, never driven low
`timescale 1ns/1ps
`default_nettype none
module pair_drive (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic data_i,
  input  wire logic stp_i,
  output logic      pos_o,
  output logic      pos_oe_n_o,
  output logic      neg_o,
  output logic      neg_oe_n_o
);
  logic pos_d;
  logic pos_oe_n_d;
  logic neg_d;
  logic neg_oe_n_d;

  // Only one leg carries the signal; the other floats
  always_comb begin
    pos_d      = stp_i ? 1'b0 : data_i;
    pos_oe_n_d = stp_i;
    neg_d      = stp_i ? data_i : 1'b0;
    neg_oe_n_d = ~stp_i;
  end

  // Reset to UTP, the default wiring
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_o      <= 1'b0;
      pos_oe_n_o <= 1'b0;
      neg_o      <= 1'b0;
      neg_oe_n_o <= 1'b1;
    end else begin
      pos_o      <= pos_d;
      pos_oe_n_o <= pos_oe_n_d;
      neg_o      <= neg_d;
      neg_oe_n_o <= neg_oe_n_d;
    end
  end
endmodule
`default_nettype wire

// File: verilog/media_select_cfg.sv
// Purpose: Jumperless base-address setup, configuration registers and media selection
// Assumes: I/O strobes are one-cycle pulses synchronous to ref_clk_i
// Notes:   Straps are captured at the first edge after reset release
`timescale 1ns/1ps
`default_nettype none
module media_select_cfg #(
  parameter int unsigned UNJAB_CYCLES = media_cfg_pkg::UNJAB_CYCLES
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire media_cfg_pkg::io_req_t io_req_i,
  output logic [7:0]                  io_rdata_o,
  output logic                        io_ack_o,
  input  wire logic                   filter_strap_pin_i,
  input  wire logic                   shield_strap_pin_i,
  input  wire logic                   autoswitch_strap_pin_i,
  input  wire logic                   link_ok_i,
  input  wire logic                   pkt_busy_i,
  input  wire logic                   jabber_i,
  input  wire logic                   tx_data_i,
  input  wire logic                   tx_predistort_i,
  output logic                        tx_out_pos_o,
  output logic                        tx_out_pos_oe_n_o,
  output logic                        tx_out_neg_o,
  output logic                        tx_out_neg_oe_n_o,
  output logic                        tx_predistort_pos_o,
  output logic                        tx_predistort_pos_oe_n_o,
  output logic                        tx_predistort_neg_o,
  output logic                        tx_predistort_neg_oe_n_o,
  output logic                        filter_en_o,
  output logic                        aui_sel_o,
  output logic                        thin_en_o,
  output logic [9:0]                  io_base_o
);

  media_cfg_pkg::cfg_regs_t   cfg_q;
  media_cfg_pkg::cfg_regs_t   cfg_d;
  media_cfg_pkg::port_state_t st_q;
  media_cfg_pkg::port_state_t st_d;
  logic       strap_done_q;
  logic       strap_done_d;
  logic       alias_used_q;
  logic       alias_used_d;
  logic [2:0] alias_cnt_q;
  logic [2:0] alias_cnt_d;
  logic       filter_q;
  logic       filter_d;
  logic [7:0] rdata_d;
  logic       ack_d;
  logic       thin_d;
  logic [9:0] base_d;
  logic       unjab_done;
  logic       reserved_mode;
  logic       alias_hit;
  logic       locked;
  logic       shield_mode;
  logic       autosw_mode;
  logic       aui_now;
  logic [9:0] base_addr;

  // Decode of the current mode bits
  assign base_addr     = media_cfg_pkg::BASE_TABLE[cfg_q.a[media_cfg_pkg::A_IOAD_MSB:media_cfg_pkg::A_IOAD_LSB]];
  assign reserved_mode = cfg_q.a[media_cfg_pkg::A_IOAD_MSB:media_cfg_pkg::A_IOAD_LSB]
                         == media_cfg_pkg::IOAD_RESERVED;
  assign locked        = cfg_q.c[media_cfg_pkg::C_LOCK];
  assign shield_mode   = cfg_q.c[media_cfg_pkg::C_SHIELD];
  assign autosw_mode   = cfg_q.c[media_cfg_pkg::C_AUTOSW];
  assign aui_now       = (st_q == media_cfg_pkg::ST_AUI) || (st_q == media_cfg_pkg::ST_TO_TP);
  // Alias answers only in reserved mode and before its single use
  assign alias_hit     = reserved_mode && !alias_used_q && (io_req_i.addr == media_cfg_pkg::ALIAS_ADDR);

  // Configuration registers, alias counter and strap capture
  always_comb begin
    cfg_d        = cfg_q;
    strap_done_d = 1'b1;
    alias_used_d = alias_used_q;
    alias_cnt_d  = alias_cnt_q;
    filter_d     = filter_q;
    if (!strap_done_q) begin
      filter_d                          = filter_strap_pin_i;
      cfg_d.c[media_cfg_pkg::C_SHIELD] = shield_strap_pin_i;
      cfg_d.c[media_cfg_pkg::C_AUTOSW] = autoswitch_strap_pin_i;
    end else if (io_req_i.wr && alias_hit) begin
      if (alias_cnt_q == media_cfg_pkg::ALIAS_WRITES - 3'h1) begin
        cfg_d.a[media_cfg_pkg::A_IOAD_MSB:media_cfg_pkg::A_IOAD_LSB] =
          io_req_i.data[media_cfg_pkg::A_IOAD_MSB:media_cfg_pkg::A_IOAD_LSB];
        alias_used_d = 1'b1;
        alias_cnt_d  = 3'h0;
      end else begin
        alias_cnt_d = alias_cnt_q + 3'h1;
      end
    end else if (io_req_i.wr || io_req_i.rd) begin
      // Any other access restarts the count
      alias_cnt_d = 3'h0;
      if (io_req_i.wr && !locked && !reserved_mode) begin
        if (io_req_i.addr == base_addr + media_cfg_pkg::OFF_CFG_A) begin
          cfg_d.a = io_req_i.data;
        end else if (io_req_i.addr == base_addr + media_cfg_pkg::OFF_CFG_B) begin
          cfg_d.b = io_req_i.data;
        end else if (io_req_i.addr == base_addr + media_cfg_pkg::OFF_CFG_C) begin
          cfg_d.c = io_req_i.data;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q        <= '{a: media_cfg_pkg::CFG_A_RST, b: media_cfg_pkg::CFG_B_RST, c: media_cfg_pkg::CFG_C_RST};
      strap_done_q <= 1'b0;
      alias_used_q <= 1'b0;
      alias_cnt_q  <= 3'h0;
      filter_q     <= 1'b0;
    end else begin
      cfg_q        <= cfg_d;
      strap_done_q <= strap_done_d;
      alias_used_q <= alias_used_d;
      alias_cnt_q  <= alias_cnt_d;
      filter_q     <= filter_d;
    end
  end

  // Read path; link status is live so software can watch auto-switch decisions
  always_comb begin
    rdata_d = 8'h00;
    ack_d   = io_req_i.rd || io_req_i.wr;
    if (io_req_i.rd) begin
      if (alias_hit) begin
        rdata_d = cfg_q.a;
      end else if (!reserved_mode && io_req_i.addr == base_addr + media_cfg_pkg::OFF_CFG_A) begin
        rdata_d = cfg_q.a;
      end else if (!reserved_mode && io_req_i.addr == base_addr + media_cfg_pkg::OFF_CFG_B) begin
        rdata_d                          = cfg_q.b;
        rdata_d[media_cfg_pkg::B_GDLINK] = link_ok_i;
      end else if (!reserved_mode && io_req_i.addr == base_addr + media_cfg_pkg::OFF_CFG_C) begin
        rdata_d = cfg_q.c;
      end
    end
  end

  // Unjab interval after the end of jabbering
  unjab_timer #(
    .CYCLES (UNJAB_CYCLES)
  ) u_unjab (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .jabber_i  (jabber_i),
    .done_o    (unjab_done)
  );

  // Port selection; without auto-switch twisted pair stays selected
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      media_cfg_pkg::ST_TP: begin
        if (autosw_mode && !link_ok_i) begin
          st_d = media_cfg_pkg::ST_TO_AUI;
        end
      end
      media_cfg_pkg::ST_TO_AUI: begin
        if (!autosw_mode || link_ok_i) begin
          st_d = media_cfg_pkg::ST_TP;
        end else if (!pkt_busy_i && !jabber_i && unjab_done) begin
          st_d = media_cfg_pkg::ST_AUI;
        end
      end
      media_cfg_pkg::ST_AUI: begin
        if (!autosw_mode || link_ok_i) begin
          st_d = media_cfg_pkg::ST_TO_TP;
        end
      end
      media_cfg_pkg::ST_TO_TP: begin
        if (autosw_mode && !link_ok_i) begin
          st_d = media_cfg_pkg::ST_AUI;
        end else if (!pkt_busy_i) begin
          st_d = media_cfg_pkg::ST_TP;
        end
      end
      default: begin
        st_d = media_cfg_pkg::ST_TP;
      end
    endcase
  end

  // Registered status outputs
  always_comb begin
    thin_d = autosw_mode && ((st_d == media_cfg_pkg::ST_AUI) || (st_d == media_cfg_pkg::ST_TO_TP));
    base_d = base_addr;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q        <= media_cfg_pkg::ST_TP;
      io_rdata_o  <= 8'h00;
      io_ack_o    <= 1'b0;
      filter_en_o <= 1'b0;
      aui_sel_o   <= 1'b0;
      thin_en_o   <= 1'b0;
      io_base_o   <= 10'h000;
    end else begin
      st_q        <= st_d;
      io_rdata_o  <= rdata_d;
      io_ack_o    <= ack_d;
      filter_en_o <= filter_d;
      aui_sel_o   <= (st_d == media_cfg_pkg::ST_AUI) || (st_d == media_cfg_pkg::ST_TO_TP);
      thin_en_o   <= thin_d;
      io_base_o   <= base_d;
    end
  end

  pair_drive u_tx_pair (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .data_i     (tx_data_i),
    .stp_i      (shield_mode),
    .pos_o      (tx_out_pos_o),
    .pos_oe_n_o (tx_out_pos_oe_n_o),
    .neg_o      (tx_out_neg_o),
    .neg_oe_n_o (tx_out_neg_oe_n_o)
  );

  pair_drive u_pd_pair (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .data_i     (tx_predistort_i),
    .stp_i      (shield_mode),
    .pos_o      (tx_predistort_pos_o),
    .pos_oe_n_o (tx_predistort_pos_oe_n_o),
    .neg_o      (tx_predistort_neg_o),
    .neg_oe_n_o (tx_predistort_neg_oe_n_o)
  );

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_alias_read_data: assert property (
    strap_done_q && io_req_i.rd && alias_hit |=> io_rdata_o == $past(cfg_q.a))
    else $error("alias read did not return config A");
  chk_alias_fourth_load: assert property (strap_done_q && io_req_i.wr && alias_hit && alias_cnt_q == 3'h3
    |=> cfg_q.a[2:0] == $past(io_req_i.data[2:0]) && alias_used_q)
    else $error("fourth alias write did not load base bits");
  chk_alias_once_only: assert property (alias_used_q |=> alias_used_q && !alias_hit)
    else $error("alias location usable again before reset");
  chk_filter_strap: assert property (!strap_done_q ##1 1'b1 |-> filter_q == $past(filter_strap_pin_i))
    else $error("filter strap not captured");
  chk_strap_bits: assert property (!strap_done_q |=> shield_mode == $past(shield_strap_pin_i)
    && autosw_mode == $past(autoswitch_strap_pin_i))
    else $error("shield or auto-switch strap not captured");
  chk_utp_legs: assert property (!shield_mode |=> !tx_out_pos_oe_n_o && tx_out_neg_oe_n_o
    && !tx_predistort_pos_oe_n_o && tx_predistort_neg_oe_n_o)
    else $error("UTP leg enables wrong");
  chk_stp_legs: assert property (shield_mode |=> tx_out_pos_oe_n_o && !tx_out_neg_oe_n_o
    && tx_predistort_pos_oe_n_o && !tx_predistort_neg_oe_n_o)
    else $error("STP leg enables wrong");
  chk_switch_waits: assert property (
    st_q == media_cfg_pkg::ST_TO_AUI && (pkt_busy_i || jabber_i || !unjab_done)
    |=> st_q != media_cfg_pkg::ST_AUI)
    else $error("switched to AUI during packet or jabber");
  chk_jabber_hold: assert property ($fell(jabber_i) |-> unjab_done == 1'b0 ##1 !unjab_done)
    else $error("unjab interval skipped");
  chk_link_loss: assert property (autosw_mode && !link_ok_i && st_q == media_cfg_pkg::ST_TP
    |=> st_q == media_cfg_pkg::ST_TO_AUI)
    else $error("link loss not followed");
  chk_autosw_enable: assert property (!autosw_mode |=> st_q != media_cfg_pkg::ST_TO_AUI)
    else $error("auto-switch acted while disabled");
  chk_thin_aui: assert property (1'b1 |=> thin_en_o == ($past(autosw_mode) && aui_now))
    else $error("thin enable does not follow AUI");
  chk_lock_refuse: assert property (strap_done_q && locked && !(io_req_i.wr && alias_hit) |=> $stable(cfg_q))
    else $error("locked configuration changed");
  chk_count_restart: assert property (strap_done_q && (io_req_i.wr || io_req_i.rd)
    && !(io_req_i.wr && alias_hit) |=> alias_cnt_q == 3'h0)
    else $error("alias count not restarted");

endmodule
`default_nettype wire

// File: tb/isa_host_model.sv
// Purpose: Host software side of the ISA I/O bus for the configuration block
// Assumes: Strobes are one-cycle pulses launched 1 ns after a clock edge
// Notes:   Idle address and data show the inverse of the last cycle; reads and writes note their answer
`timescale 1ns/1ps
`default_nettype none
module isa_host_model (
  input  wire logic                  ref_clk_i,
  output var media_cfg_pkg::io_req_t io_req_o
);
  // Expected answer of each cycle, oldest first; writes answer 00
  logic [7:0] exp_q[$];

  initial io_req_o = '0;

  // One single-byte cycle; the strobe stands for exactly one edge
  task automatic access(input logic wr, input logic [9:0] addr, input logic [7:0] data, input logic [7:0] exp);
    exp_q.push_back(wr ? 8'h00 : exp);
    @(posedge ref_clk_i);
    #1;
    io_req_o = '{wr: wr, rd: ~wr, addr: addr, data: data};
    @(posedge ref_clk_i);
    #1;
    io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
  endtask

  // caller passes a conflict-free base code
  task automatic alias_load(input logic [7:0] data);
    repeat (4) access(1'b1, media_cfg_pkg::ALIAS_ADDR, data, 8'h00);
  endtask

  task automatic autoswitch_on(input logic [9:0] base);
    access(1'b1, base + media_cfg_pkg::OFF_CFG_B, 8'h04, 8'h00);
    access(1'b1, base + media_cfg_pkg::OFF_CFG_C, 8'h30, 8'h00);
  endtask
endmodule
`default_nettype wire

// File: tb/test_media_select_and_jumperless_config.sv
// Purpose: Self-checking bench for jumperless setup and media selection
// Assumes: Unjab interval shortened to 8 cycles
// Notes:   Read data is checked against answers noted by the host model
`timescale 1ns/1ps
`default_nettype none
module test_media_select_and_jumperless_config;
  logic                   ref_clk_i = 1'b0;
  logic                   rst_i     = 1'b1;
  logic                   filt_s    = 1'b0;
  logic                   shld_s    = 1'b0;
  logic                   asw_s     = 1'b0;
  logic                   link_ok   = 1'b1;
  logic                   pkt_busy  = 1'b0;
  logic                   jabber    = 1'b0;
  logic                   tx_data   = 1'b0;
  logic                   tx_pd     = 1'b0;
  media_cfg_pkg::io_req_t io_req;
  logic [7:0]             rdata;
  logic                   ack;
  logic                   pos_oe_n, neg_oe_n, pdp_oe_n, pdn_oe_n;
  logic                   tx_pos, tx_neg, pd_pos, pd_neg;
  logic [1:0]             tx_seen = 2'h0;
  logic                   live    = 1'b0;
  logic                   filter_en, aui_sel, thin_en;
  logic [9:0]             io_base;
  int                     fails   = 0;
  int                     checked = 0;
  int                     cycles  = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  isa_host_model host_u (.ref_clk_i(ref_clk_i), .io_req_o(io_req));

  media_select_cfg #(.UNJAB_CYCLES(8)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .io_req_i(io_req), .io_rdata_o(rdata), .io_ack_o(ack),
    .filter_strap_pin_i(filt_s), .shield_strap_pin_i(shld_s), .autoswitch_strap_pin_i(asw_s),
    .link_ok_i(link_ok), .pkt_busy_i(pkt_busy), .jabber_i(jabber), .tx_data_i(tx_data),
    .tx_predistort_i(tx_pd), .tx_out_pos_o(tx_pos), .tx_out_pos_oe_n_o(pos_oe_n), .tx_out_neg_o(tx_neg),
    .tx_out_neg_oe_n_o(neg_oe_n), .tx_predistort_pos_o(pd_pos), .tx_predistort_pos_oe_n_o(pdp_oe_n),
    .tx_predistort_neg_o(pd_neg), .tx_predistort_neg_oe_n_o(pdn_oe_n), .filter_en_o(filter_en),
    .aui_sel_o(aui_sel), .thin_en_o(thin_en), .io_base_o(io_base)
  );

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, 8'h00);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    host_u.access(1'b0, a, 8'h00, e);
  endtask

  // Bounded wait for the port choice, then compare
  task automatic wait_aui(input logic exp, input int max);
    int n;
    n = 0;
    while (aui_sel !== exp && n < max) begin
      cyc(1);
      n++;
    end
    check("aui select", aui_sel, exp);
    check("thin enable", thin_en, exp);
  endtask

  // Power-on reset with the given strap levels
  task automatic boot(input logic f, input logic s, input logic a);
    rst_i  = 1'b1;
    filt_s = f;
    shld_s = s;
    asw_s  = a;
    cyc(8);
    rst_i = 1'b0;
    cyc(2);
  endtask

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end

  // Random line data keeps the driven legs toggling; the value the design takes at this edge is kept
  always @(posedge ref_clk_i) begin
    tx_seen = {tx_data, tx_pd};
    live    = ~rst_i;
    #1;
    tx_data = 1'($urandom_range(1));
    tx_pd   = 1'($urandom_range(1));
  end

  // Each answer is matched with the oldest noted expectation; sampled mid-cycle where outputs are settled
  always @(negedge ref_clk_i) begin
    if (live && !rst_i) begin
      // Active leg carries the sampled line data, the released leg rests at 0
      check("tx pos leg", {9'h000, tx_pos}, {9'h000, pos_oe_n ? 1'b0 : tx_seen[1]});
      check("tx neg leg", {9'h000, tx_neg}, {9'h000, neg_oe_n ? 1'b0 : tx_seen[1]});
      check("pd pos leg", {9'h000, pd_pos}, {9'h000, pdp_oe_n ? 1'b0 : tx_seen[0]});
      check("pd neg leg", {9'h000, pd_neg}, {9'h000, pdn_oe_n ? 1'b0 : tx_seen[0]});
    end
    if (ack === 1'b1) begin
      if (host_u.exp_q.size() == 0) begin
        check("unexpected ack", 10'h001, 10'h000);
      end else begin
        check("io read data", {2'b00, rdata}, {2'b00, host_u.exp_q.pop_front()});
      end
    end
  end

  initial begin
    void'($urandom(11));
    boot(1'b1, 1'b0, 1'b0);
    check("filter enable", filter_en, 1'b1);
    check("utp oe_n", {pos_oe_n, pdp_oe_n, neg_oe_n, pdn_oe_n}, 4'b0011);
    rd(media_cfg_pkg::ALIAS_ADDR, media_cfg_pkg::CFG_A_RST);
    rd(10'h30A, 8'h00);
    // Interrupted alias run must restart the count
    repeat (3) wr(media_cfg_pkg::ALIAS_ADDR, 8'h02);
    rd(10'h300, 8'h00);
    wr(media_cfg_pkg::ALIAS_ADDR, 8'h03);
    repeat (2) wr(media_cfg_pkg::ALIAS_ADDR, 8'h01);
    cyc(3);
    check("base before fourth", io_base, 10'h000);
    wr(media_cfg_pkg::ALIAS_ADDR, 8'h01);
    cyc(3);
    check("base after alias", io_base, 10'h280);
    rd(10'h28A, 8'h01);
    // Back to reserved mode; a second alias load is ignored
    wr(10'h28A, 8'h07);
    host_u.alias_load(8'h00);
    cyc(3);
    check("base second alias", io_base, 10'h000);
    boot(1'b0, 1'b1, 1'b1);
    check("filter off", filter_en, 1'b0);
    check("stp oe_n", {pos_oe_n, pdp_oe_n, neg_oe_n, pdn_oe_n}, 4'b1100);
    host_u.alias_load(8'h00);
    cyc(3);
    check("base after reset", io_base, 10'h300);
    rd(10'h30C, 8'h70);
    rd(10'h30A, 8'h00);
    // Link loss during a packet: switch waits for its end
    link_ok  = 1'b0;
    pkt_busy = 1'b1;
    cyc(6);
    check("aui during packet", aui_sel, 1'b0);
    pkt_busy = 1'b0;
    wait_aui(1'b1, 4);
    link_ok = 1'b1;
    wait_aui(1'b0, 4);
    // Software overrides the straps
    wr(10'h30C, 8'h20);
    cyc(3);
    check("utp by software", {pos_oe_n, pdp_oe_n, neg_oe_n, pdn_oe_n}, 4'b0011);
    link_ok = 1'b0;
    cyc(8);
    check("no switch when off", aui_sel, 1'b0);
    host_u.autoswitch_on(10'h300);
    wait_aui(1'b1, 6);
    link_ok = 1'b1;
    wait_aui(1'b0, 4);
    // Link fail while jabbering waits for the unjab interval
    jabber  = 1'b1;
    link_ok = 1'b0;
    cyc(20);
    check("aui while jabber", aui_sel, 1'b0);
    jabber = 1'b0;
    cyc(4);
    check("aui during unjab", aui_sel, 1'b0);
    wait_aui(1'b1, 12);
    // Lock with shield by D6, then a refused write
    wr(10'h30C, 8'hF0);
    cyc(3);
    check("stp by D6", {pos_oe_n, neg_oe_n}, 2'b10);
    wr(10'h30C, 8'h20);
    rd(10'h30C, 8'hF0);
    cyc(3);
    check("locked stays stp", {pos_oe_n, neg_oe_n}, 2'b10);
    cyc(4);
    check("acks outstanding", 10'(host_u.exp_q.size()), 10'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
